// ---- hw/hmsp_port.v ----
// Contract
// - i2c writes feed parser, never registers
// - ack own address with read or write bit
// - single-byte write only sets pointer
// - select pin chooses spi or uart/i2c
// - spi peripheral only, msb first
// - spi full duplex, byte per byte
// - parser off after 50 0xFF bytes
// - spi out equals stream register read
// - pending pin active at threshold, polarity
// - pending indicator disabled after reset
// - bad pin choice zeroes indicator settings
// - two seconds silence idles the port
// - extended timeout waits for 4kB pending
// - stream register returns bytes or 0xFF
// - count registers report available bytes
// - pointer starts 0xFF, sticks at 0xFF
`timescale 1ns/1ps
`include "hmsp_consts.vh"
module hmsp_port #(
	parameter IDLE_CYCLES = `HMSP_IDLE_MS * `HMSP_CLK_KHZ, // two seconds
	parameter I2C_ADDR    = 7'h42                          // own address, arbitrary
)(
	input  wire        core_clk,      // system clock
	input  wire        sys_rst,       // sync reset, high
	input  wire        iface_sel,     // 0 spi, 1 uart/i2c
	input  wire        pin42_in,      // shared pin 42 level
	input  wire        pin43_in,      // shared pin 43 level
	input  wire        pin44_in,      // sda or chip select
	input  wire        pin45_in,      // scl or spi clock
	output reg         pin42_out,     // data out / uart tx
	output reg         pin42_oe,      // pin 42 enable
	output reg         pin44_out,     // sda drive (always low)
	output reg         pin44_oe,      // sda pull low
	output reg  [7:0]  rx_data,       // parser byte
	output reg         rx_valid,      // parser byte pulse
	input  wire        rx_ready,      // parser has space
	input  wire [7:0]  tx_data,       // pending output byte
	input  wire        tx_avail,      // output byte waiting
	output reg         tx_take,       // pop pulse
	input  wire [15:0] tx_count,      // pending bytes
	input  wire        uart_tx,       // uart tx from framer
	output reg         uart_rx,       // uart rx to framer
	input  wire        ind_cfg_we,    // pending_indicator_config write
	input  wire        ind_cfg_en,    // enable
	input  wire        ind_cfg_pol,   // 1 active high
	input  wire [1:0]  ind_cfg_pin,   // pin choice
	input  wire [15:0] ind_cfg_thr,   // threshold bytes
	input  wire [3:0]  pin_busy,      // pins used elsewhere
	input  wire        ext_timeout,   // extended timeout enable
	output reg         ind_en,        // readback enable
	output reg         ind_pol,       // readback polarity
	output reg  [15:0] ind_thr,       // readback threshold
	output reg  [3:0]  ind_pins,      // indicator pins
	output reg         port_idle,     // port idled
	output reg         parse_on       // spi parser active
);
////////////////////////////////////////////////////////////////////////////////
	// three-stage samplers on pins 43, 44 and 45
	reg [2:0] s44;  // sda / cs
	reg [2:0] s45;  // scl / sck
	reg [2:0] s43;  // sdi / rxd
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			s44 <= 3'h7;
			s45 <= 3'h7;
			s43 <= 3'h7;
		end
		else
		begin
			s44 <= {s44[1:0], pin44_in};
			s45 <= {s45[1:0], pin45_in};
			s43 <= {s43[1:0], pin43_in};
		end
	end
	// stable levels where stages two and three agree
	reg l44, l45, l43, p44, p45;
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			l44 <= 1'h1;
			l45 <= 1'h1;
			l43 <= 1'h1;
			p44 <= 1'h1;
			p45 <= 1'h1;
		end
		else
		begin
			if (s44[1] == s44[2]) l44 <= s44[2];
			if (s45[1] == s45[2]) l45 <= s45[2];
			if (s43[1] == s43[2]) l43 <= s43[2];
			p44 <= l44;
			p45 <= l45;
		end
	end
	wire rise45 = l45 & ~p45;
	wire fall45 = ~l45 & p45;
	wire spi_m  = ~iface_sel;
	wire cs_act = spi_m & ~l44;
	wire i2c_st = iface_sel & l45 & p44 & ~l44;                   // start
	wire i2c_sp = iface_sel & l45 & ~p44 & l44;                   // stop
////////////////////////////////////////////////////////////////////////////////
	// shift engine shared by spi and i2c
	localparam ST_IDLE = 2'h0, ST_ADDR = 2'h1, ST_DATA = 2'h2, ST_READ = 2'h3;
	reg [1:0]  st;       // i2c state
	reg [7:0]  sh;       // input shift
	reg [7:0]  osh;      // output shift
	reg [3:0]  bc;       // bit count
	reg        ackph;    // i2c ack slot
	reg [7:0]  ptr;      // i2c address pointer
	reg [7:0]  first;    // held newest data byte
	reg [1:0]  nbytes;   // data bytes so far, saturating
	reg [6:0]  ffcnt;    // consecutive 0xFF
	reg [31:0] idle_cnt; // cycles without transfer
	wire [7:0] sh_nx = {sh[6:0], spi_m ? l43 : l44};
	wire [7:0] stream_b = tx_avail ? tx_data : `HMSP_IDLE_BYTE;
	reg  [7:0] rd_b;
	always @*
	begin
		case (ptr)
			`HMSP_REG_STREAM: rd_b = stream_b;
			`HMSP_REG_CNT_HI: rd_b = tx_count[15:8];
			`HMSP_REG_CNT_LO: rd_b = tx_count[7:0];
			default:          rd_b = 8'h00;
		endcase
	end
	// main transfer process
	always @(posedge core_clk)
	begin
		rx_valid <= 1'h0;
		tx_take  <= 1'h0;
		if (sys_rst)
		begin
			st <= ST_IDLE;
			sh <= 8'h00;
			osh <= `HMSP_IDLE_BYTE;
			bc <= 4'h0;
			ackph <= 1'h0;
			ptr <= `HMSP_PTR_RESET;
			first <= 8'h00;
			nbytes <= 2'h0;
			ffcnt <= 7'h00;
			parse_on <= 1'h1;
			rx_data <= 8'h00;
			pin42_out <= 1'h1;
			pin42_oe <= 1'h0;
			pin44_out <= 1'h0;
			pin44_oe <= 1'h0;
			uart_rx <= 1'h1;
			idle_cnt <= 32'h0;
			port_idle <= 1'h0;
		end
		else
		begin
			uart_rx   <= iface_sel ? l43 : 1'h1;
			pin42_oe  <= spi_m ? cs_act : 1'h1;
			if (iface_sel)
				pin42_out <= uart_tx;
			else
				pin42_out <= osh[7];
			// idle timer, restarted by each rising clock edge of a transfer
			if (rise45 && (cs_act || st != ST_IDLE))
			begin
				idle_cnt <= 32'h0;
				port_idle <= 1'h0;
			end
			else if (idle_cnt >= IDLE_CYCLES - 1)
			begin
				// extended mode holds off until 4 kB pending
				if (!ext_timeout || tx_count >= `HMSP_EXT_LIMIT)
					port_idle <= 1'h1;
			end
			else
				idle_cnt <= idle_cnt + 32'h1;
			if (spi_m)
			begin
				pin44_oe <= 1'h0;
				st <= ST_IDLE;
				if (!cs_act)
				begin
					bc <= 4'h0;
					osh <= stream_b;
				end
				else if (rise45)
				begin
					sh <= sh_nx;
					if (bc == 4'h7)
					begin
						bc <= 4'h0;
						if (tx_avail) tx_take <= 1'h1;
						if (sh_nx == `HMSP_IDLE_BYTE)
						begin
							if (ffcnt != `HMSP_FF_LIMIT) ffcnt <= ffcnt + 7'h1;
							if (ffcnt + 7'h1 >= `HMSP_FF_LIMIT) parse_on <= 1'h0;
						end
						else
						begin
							ffcnt <= 7'h00;
							parse_on <= 1'h1;
						end
						if ((parse_on && !(ffcnt + 7'h1 >= `HMSP_FF_LIMIT &&
							sh_nx == `HMSP_IDLE_BYTE)) || sh_nx != `HMSP_IDLE_BYTE)
						begin
							rx_data <= sh_nx;
							rx_valid <= rx_ready;
						end
					end
					else
						bc <= bc + 4'h1;
				end
				else if (fall45 && bc != 4'h0)
					osh <= {osh[6:0], 1'h1};
				else if (fall45)
					osh <= tx_take ? stream_b : osh;
			end
			else if (i2c_st)
			begin
				st <= ST_ADDR;
				bc <= 4'h0;
				ackph <= 1'h0;
				nbytes <= 2'h0;
				pin44_oe <= 1'h0;
			end
			else if (i2c_sp)
			begin
				// a lone byte only moves the pointer
				if (st == ST_DATA && nbytes == 2'h1) ptr <= first;
				// flush the held last byte of a message write
				if (st == ST_DATA && nbytes == 2'h2)
				begin
					rx_data  <= first;
					rx_valid <= rx_ready;
				end
				st <= ST_IDLE;
				pin44_oe <= 1'h0;
			end
			else if (st != ST_IDLE && rise45 && !ackph)
			begin
				sh <= sh_nx;
				bc <= bc + 4'h1;
				if (st == ST_READ && bc == 4'h7) ackph <= 1'h1;
			end
			else if (st != ST_IDLE && fall45)
			begin
				if (ackph)
				begin
					ackph <= 1'h0;
					pin44_oe <= 1'h0;
					if (st == ST_READ)
					begin
						if (s44[2]) st <= ST_IDLE;                 // nack ends read
						else
						begin
							pin44_oe <= ~rd_b[7];
							osh <= {rd_b[6:0], 1'h1};
							if (ptr == `HMSP_REG_STREAM && tx_avail) tx_take <= 1'h1;
							if (ptr != `HMSP_REG_STREAM) ptr <= ptr + 8'h1;
						end
					end
				end
				else if (bc == 4'h8)
				begin
					bc <= 4'h0;
					if (st == ST_ADDR)
					begin
						if (sh[7:1] == I2C_ADDR)
						begin
							ackph <= 1'h1;
							pin44_oe <= 1'h1;
							st <= (sh[0] == `HMSP_RW_WRITE) ? ST_DATA : ST_READ;
						end
						else
							st <= ST_IDLE;
					end
					else if (st == ST_DATA)
					begin
						ackph <= 1'h1;
						pin44_oe <= rx_ready;
						// held byte reaches only the parser, newest is held
						if (nbytes != 2'h0)
						begin
							rx_data <= first;
							rx_valid <= rx_ready;
						end
						first <= sh;
						if (nbytes != 2'h2)
							nbytes <= nbytes + 2'h1;
					end
				end
				else if (st == ST_READ)
				begin
					pin44_oe <= ~osh[7];
					osh <= {osh[6:0], 1'h1};
				end
			end
		end
	end
////////////////////////////////////////////////////////////////////////////////
	// pending indicator configuration and pins
	reg [1:0] ind_sel; // chosen pin
	genvar g;
	generate
		for (g = 0; g < `HMSP_PIN_COUNT; g = g + 1)
		begin : g_ind
			always @(posedge core_clk)
			begin
				if (sys_rst)
					ind_pins[g] <= 1'h0;
				else if (ind_en && ind_sel == g)
					ind_pins[g] <= ((tx_count >= ind_thr) && tx_avail) ~^ ind_pol;
				else
					ind_pins[g] <= 1'h0;
			end
		end
	endgenerate
	// configuration capture with pin validity check
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			ind_en  <= 1'h0;
			ind_pol <= 1'h0;
			ind_thr <= 16'h0000;
			ind_sel <= 2'h0;
		end
		else if (ind_cfg_we)
		begin
			if (ind_cfg_en && !pin_busy[ind_cfg_pin])
			begin
				ind_en  <= 1'h1;
				ind_pol <= ind_cfg_pol;
				ind_thr <= ind_cfg_thr;
				ind_sel <= ind_cfg_pin;
			end
			else
			begin
				ind_en  <= 1'h0;
				ind_pol <= 1'h0;
				ind_thr <= 16'h0000;
				ind_sel <= 2'h0;
			end
		end
	end
endmodule // hmsp_port

// ---- hw/hmsp_consts.vh ----
`ifndef HMSP_CONSTS_VH
`define HMSP_CONSTS_VH
// byte values
`define HMSP_IDLE_BYTE      8'hFF
`define HMSP_RW_WRITE       1'h0
// i2c register map
`define HMSP_REG_STREAM     8'hFF
`define HMSP_REG_CNT_HI     8'hFD
`define HMSP_REG_CNT_LO     8'hFE
`define HMSP_PTR_RESET      8'hFF
// spi parser shut-off count
`define HMSP_FF_LIMIT       7'h32
// idle timeout figures
`define HMSP_IDLE_MS        2000
`define HMSP_CLK_KHZ        100000
`define HMSP_EXT_LIMIT      16'h1000
// pending indicator pin count
`define HMSP_PIN_COUNT      4
`endif

// ---- sim/hmsp_port_checker.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// port-level checks, bound into every hmsp_port instance
module hmsp_port_checker (
	input wire        core_clk,
	input wire        sys_rst,
	input wire        iface_sel,
	input wire        pin44_in,
	input wire        pin42_oe,
	input wire        pin44_out,
	input wire        pin44_oe,
	input wire [7:0]  rx_data,
	input wire        rx_valid,
	input wire        tx_avail,
	input wire        tx_take,
	input wire        uart_rx,
	input wire        ind_cfg_we,
	input wire [1:0]  ind_cfg_pin,
	input wire [3:0]  pin_busy,
	input wire        ind_en,
	input wire        ind_pol,
	input wire [15:0] ind_thr,
	input wire [3:0]  ind_pins,
	input wire        parse_on
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	AST_UART_IDLE: assert property (!iface_sel[*3] |-> uart_rx)
		else $error("uart rx not idle in spi mode");
	AST_UART_OE: assert property (iface_sel[*3] |-> pin42_oe)
		else $error("tx pin not driven in uart mode");
	AST_SPI_DESEL: assert property ((!iface_sel && pin44_in)[*6] |-> !pin42_oe)
		else $error("data out driven while deselected");
	AST_SDA_SPI: assert property (!iface_sel[*3] |-> !pin44_oe)
		else $error("sda pulled in spi mode");
	AST_ACK_LOW: assert property (pin44_oe |-> !pin44_out)
		else $error("sda driven high");
	AST_RX_PULSE: assert property (rx_valid |=> !rx_valid)
		else $error("parser strobe longer than one cycle");
	AST_TAKE_AVAIL: assert property (tx_take |-> tx_avail || $past(tx_avail))
		else $error("pop without pending byte");
	AST_IND_OFF: assert property (!ind_en |-> ind_pins == 4'h0 && ind_thr == 16'h0000 && !ind_pol)
		else $error("disabled indicator not zero");
	AST_BUSY_PIN: assert property (ind_cfg_we && pin_busy[ind_cfg_pin] |=> !ind_en)
		else $error("busy pin accepted");
	AST_FF_GATE: assert property (rx_valid && rx_data == 8'hFF |-> $past(parse_on))
		else $error("idle byte passed while parser off");
endmodule // hmsp_port_checker
bind hmsp_port hmsp_port_checker u_chk (.core_clk, .sys_rst, .iface_sel, .pin44_in, .pin42_oe,
	.pin44_out, .pin44_oe, .rx_data, .rx_valid, .tx_avail, .tx_take, .uart_rx, .ind_cfg_we,
	.ind_cfg_pin, .pin_busy, .ind_en, .ind_pol, .ind_thr, .ind_pins, .parse_on);

// ---- sim/hmsp_host_model.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// host controller: spi or i2c, link clock idles between frames
module hmsp_host_model (
	input wire  pin42_out, // device data out
	input wire  pin44_oe,  // device pulls sda low
	output reg  pin43_lvl, // host data out
	output wire pin44_lvl, // chip select / sda wire
	output reg  pin45_lvl  // spi clock / scl
);
	reg drv44; // host side of select / sda
	assign pin44_lvl = drv44 & ~pin44_oe; // open drain with pull-up
	initial
	begin
		drv44 = 1'b1;
		pin43_lvl = 1'b1;
		pin45_lvl = 1'b0;
	end
	// one full-duplex byte, msb first, 125 ns link clock
	task spi_byte(input [7:0] tx, output [7:0] rx);
		integer i;
		begin
			drv44 = 1'b0;
			#100;
			for (i = 7; i >= 0; i = i - 1)
			begin
				pin43_lvl = tx[i];
				#62.5 pin45_lvl = 1'b1;
				rx[i] = pin42_out;
				#62.5 pin45_lvl = 1'b0;
			end
			#100 drv44 = 1'b1;
			pin43_lvl = ~pin43_lvl; // released line shows the inverse
			#200;
		end
	endtask
	task i2c_start;
	begin
		drv44 = 1'b1;
		pin45_lvl = 1'b1;
		#125 drv44 = 1'b0;
		#125 pin45_lvl = 1'b0;
	end
	endtask
	// stop right after the last data byte
	task i2c_stop;
	begin
		drv44 = 1'b0;
		#125 pin45_lvl = 1'b1;
		#125 drv44 = 1'b1;
		#250;
	end
	endtask
	// eight bits then a released ack slot
	task i2c_byte(input [7:0] b, output ack);
		integer i;
		reg [8:0] sh;
		begin
			sh = {b, 1'b1};
			for (i = 8; i >= 0; i = i - 1)
			begin
				drv44 = sh[i];
				#125 pin45_lvl = 1'b1;
				ack = pin44_lvl;
				#125 pin45_lvl = 1'b0;
			end
		end
	endtask
endmodule // hmsp_host_model

// ---- sim/hmsp_port_bench.sv ----
`timescale 1ns/1ps
module hmsp_port_bench;
	reg core_clk = 1'b0, sys_rst = 1'b1, iface_sel = 1'b0, rx_ready = 1'b1;
	reg [7:0] tx_data = 8'h00;
	reg tx_avail = 1'b0, ind_cfg_we = 1'b0, ind_cfg_en = 1'b0, ind_cfg_pol = 1'b0;
	reg [15:0] tx_count = 16'h0000, ind_cfg_thr = 16'h0000;
	reg [1:0] ind_cfg_pin = 2'h0;
	reg [3:0] pin_busy = 4'h0;
	reg ext_timeout = 1'b0, ack;
	wire pin42_out, pin42_oe, pin44_out, pin44_oe, rx_valid, tx_take, uart_rx, ind_en;
	wire ind_pol, port_idle, parse_on, p43, p44, p45;
	wire [7:0] rx_data;
	wire [15:0] ind_thr;
	wire [3:0] ind_pins;
	reg [7:0] got, rx_last = 8'h00;
	reg [15:0] rx_cnt = 16'h0000, take_cnt = 16'h0000, n;
	integer bad_count = 0, checks_done = 0, i;
	always #5 core_clk = ~core_clk;
	hmsp_port #(.IDLE_CYCLES(1000), .I2C_ADDR(7'h42)) u_hmsp_port (.core_clk, .sys_rst,
		.iface_sel, .pin42_in(1'b1), .pin43_in(p43), .pin44_in(p44), .pin45_in(p45), .pin42_out,
		.pin42_oe, .pin44_out, .pin44_oe, .rx_data, .rx_valid, .rx_ready, .tx_data, .tx_avail,
		.tx_take, .tx_count, .uart_tx(1'b1), .uart_rx, .ind_cfg_we, .ind_cfg_en, .ind_cfg_pol,
		.ind_cfg_pin, .ind_cfg_thr, .pin_busy, .ext_timeout, .ind_en, .ind_pol, .ind_thr,
		.ind_pins, .port_idle, .parse_on);
	hmsp_host_model u_host (.pin42_out, .pin44_oe, .pin43_lvl(p43), .pin44_lvl(p44),
		.pin45_lvl(p45));
	// count parser bytes and pops
	always @(posedge core_clk)
	begin
		if (rx_valid)
		begin
			rx_last <= rx_data;
			rx_cnt <= rx_cnt + 16'h0001;
		end
		if (tx_take)
			take_cnt <= take_cnt + 16'h0001;
	end
	task step;
	begin
		@(posedge core_clk);
		#1;
	end
	endtask
	task check(input [8*12:1] what, input [15:0] seen, input [15:0] exp);
	begin
		checks_done = checks_done + 1;
		if (seen !== exp)
		begin
			bad_count = bad_count + 1;
			$display("[ERR] %0s exp %h seen %h", what, exp, seen);
		end
	end
	endtask
	task spi(input [7:0] b);
	begin
		u_host.spi_byte(b, got);
		repeat (10) step;
	end
	endtask
	task cfg;
	begin
		ind_cfg_en = 1'b1;
		ind_cfg_pol = 1'b1;
		ind_cfg_pin = 2'h2;
		ind_cfg_thr = 16'h0010;
		ind_cfg_we = 1'b1;
		step;
		ind_cfg_we = 1'b0;
		repeat (2) step;
	end
	endtask
	task test_done;
	begin
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask
	initial
	begin
		#500000;
		bad_count = bad_count + 1;
		test_done;
	end
	initial
	begin
		repeat (8) step;
		sys_rst = 1'b0;
		repeat (3) step;
		check("ind_en", ind_en, 16'h0000);
		check("parse_on", parse_on, 16'h0001);
		tx_data = 8'h3C;
		tx_avail = 1'b1;
		spi(8'hA5);
		tx_avail = 1'b0;
		check("spi rx", rx_last, 16'h00A5);
		check("spi tx", got, 16'h003C);
		check("pops", take_cnt, 16'h0001);
		spi(8'h5A);
		check("empty tx", got, 16'h00FF);
		rx_ready = 1'b0;
		spi(8'h34);
		rx_ready = 1'b1;
		check("refused", rx_last, 16'h005A);
		$display("test spi done");
		for (i = 0; i < 49; i = i + 1)
			spi(8'hFF);
		check("parse 49", parse_on, 16'h0001);
		spi(8'hFF);
		check("parse 50", parse_on, 16'h0000);
		spi(8'h12);
		check("resume", parse_on, 16'h0001);
		check("resume byte", rx_last, 16'h0012);
		$display("test idle bytes done");
		cfg;
		check("ind thr", ind_thr, 16'h0010);
		tx_count = 16'h0010;
		tx_avail = 1'b1;
		repeat (3) step;
		check("ind active", ind_pins, 16'h0004);
		tx_count = 16'h000F;
		repeat (3) step;
		check("ind below", ind_pins, 16'h0000);
		pin_busy = 4'h4;
		cfg;
		check("busy en", ind_en, 16'h0000);
		tx_avail = 1'b0;
		$display("test indicator done");
		spi(8'h77);
		check("awake", port_idle, 16'h0000);
		repeat (1100) step;
		check("idle", port_idle, 16'h0001);
		ext_timeout = 1'b1;
		spi(8'h78);
		repeat (1100) step;
		check("ext wait", port_idle, 16'h0000);
		tx_count = 16'h1000;
		repeat (5) step;
		check("ext idle", port_idle, 16'h0001);
		$display("test timeout done");
		iface_sel = 1'b1;
		repeat (5) step;
		n = rx_cnt;
		u_host.i2c_start;
		u_host.i2c_byte(8'h84, ack);
		check("addr ack", ack, 16'h0000);
		u_host.i2c_byte(8'h55, ack);
		u_host.i2c_byte(8'hAA, ack);
		u_host.i2c_stop;
		repeat (10) step;
		check("i2c count", rx_cnt - n, 16'h0002);
		check("i2c byte", rx_last, 16'h00AA);
		u_host.i2c_start;
		u_host.i2c_byte(8'h84, ack);
		u_host.i2c_byte(8'h10, ack);
		u_host.i2c_stop;
		repeat (10) step;
		check("one byte", rx_cnt - n, 16'h0002);
		u_host.i2c_start;
		u_host.i2c_byte(8'h86, ack);
		check("other addr", ack, 16'h0001);
		u_host.i2c_stop;
		$display("test i2c done");
		test_done;
	end
endmodule // hmsp_port_bench
